// ### rtl/itp_pkg.sv
// Purpose: Constants and types for the prescaled interval timer
// Assumes: APB slave, 32-bit data, one word per register
package itp_pkg;

    // ****************************************
    // Register map
    // ****************************************
    localparam logic [11:0] ITP_OFF_COUNT    = 12'h000;
    localparam logic [11:0] ITP_OFF_PRESCALE = 12'h004;
    localparam logic [11:0] ITP_OFF_PERIOD   = 12'h008;
    localparam logic [11:0] ITP_OFF_STATUS   = 12'h00c;
    localparam logic [11:0] ITP_OFF_MASK     = 12'h010;

    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [15:0] ITP_RST_COUNT    = 16'h0000;
    localparam logic [7:0]  ITP_RST_PRESCALE = 8'h00;
    localparam logic [15:0] ITP_RST_PERIOD   = 16'h0000;
    localparam logic        ITP_RST_MASK     = 1'b0;

    // Status and mask share this layout
    localparam int          ITP_BIT_ZERO     = 0;

    typedef struct packed {
        logic        sel;
        logic        enable;
        logic        write;
        logic [11:0] addr;
        logic [31:0] wdata;
    } itp_apb_req_type;

endpackage

// ### rtl/itp_timer.sv
// Purpose: Prescaled 16-bit interval timer with APB registers and interrupt
// Assumes: Single clock, synchronous active-high reset
// Notes:   Zero status is sticky, cleared by reading the status register
//
// Added by the designer: the APB interface to the registers and the address map.
`timescale 1ns/100ps
module itp_timer
    import itp_pkg::*;
#(
    parameter int COUNT_W = 16,
    parameter int SCALE_W = 8
) (
    input  wire logic        CLK_I,
    input  wire logic        RESET_I,
    input  wire logic        PSEL_I,
    input  wire logic        PENABLE_I,
    input  wire logic        PWRITE_I,
    input  wire logic [11:0] PADDR_I,
    input  wire logic [31:0] PWDATA_I,
    output logic      [31:0] PRDATA_O,
    output logic             PREADY_O,
    output logic             PSLVERR_O,
    output logic             IRQ_O
);

    // ****************************************
    // Parameter check
    // ****************************************
    if (COUNT_W != 16 || SCALE_W != 8) begin : g_bad_width
        $error("itp_timer supports only the documented widths");
    end

    // ****************************************
    // Bus decode
    // ****************************************
    itp_apb_req_type req;
    assign req = '{sel: PSEL_I, enable: PENABLE_I, write: PWRITE_I, addr: PADDR_I, wdata: PWDATA_I};

    logic [15:0] count;
    logic [7:0]  prescale;
    logic [15:0] period;
    logic [7:0]  scale_cnt;
    logic        zero_flag;
    logic        zero_mask;

    wire         setup_ph   = req.sel && !req.enable;
    wire         access_ph  = req.sel && req.enable && PREADY_O;
    wire         hit_count  = req.addr == ITP_OFF_COUNT;
    wire         hit_scale  = req.addr == ITP_OFF_PRESCALE;
    wire         hit_period = req.addr == ITP_OFF_PERIOD;
    wire         hit_status = req.addr == ITP_OFF_STATUS;
    wire         hit_mask   = req.addr == ITP_OFF_MASK;
    wire         mapped     = hit_count | hit_scale | hit_period | hit_status | hit_mask;
    wire         wr_ok      = access_ph && req.write && mapped;
    wire         rd_status  = access_ph && !req.write && hit_status;

    wire  [31:0] rd_mux     = hit_count  ? {16'h0000, count} :
                              hit_scale  ? {24'h000000, prescale} :
                              hit_period ? {16'h0000, period} :
                              hit_status ? {31'h00000000, zero_flag} :
                              hit_mask   ? {31'h00000000, zero_mask} : 32'h00000000;

    // ****************************************
    // Timer datapath
    // ****************************************
    // prescaler expiry strobe
    wire         tick       = scale_cnt == 8'h00;
    wire  [7:0]  next_scale = tick ? prescale : scale_cnt - 8'h01;
    wire         at_zero    = tick && count == 16'h0001;
    // decrement on strobe; reload period on the strobe at count 1
    wire  [15:0] next_count = (wr_ok && hit_count) ? req.wdata[15:0] :
                              at_zero ? period :
                              tick ? count - 16'h0001 : count;
    // Set wins over the read-clear
    wire         next_flag  = at_zero | (zero_flag & ~rd_status);

    always_ff @(posedge CLK_I) begin
        if (RESET_I) begin
            count     <= ITP_RST_COUNT;
            prescale  <= ITP_RST_PRESCALE;
            period    <= ITP_RST_PERIOD;
            scale_cnt <= ITP_RST_PRESCALE;
            zero_flag <= 1'b0;
            zero_mask <= ITP_RST_MASK;
        end else begin
            // runs every cycle, bus never stalls it
            count     <= next_count;
            scale_cnt <= next_scale;
            zero_flag <= next_flag;
            if (wr_ok && hit_scale) begin
                prescale <= req.wdata[7:0];
            end
            if (wr_ok && hit_period) begin
                period <= req.wdata[15:0];
            end
            if (wr_ok && hit_mask) begin
                zero_mask <= req.wdata[ITP_BIT_ZERO];
            end
        end
    end

    // ****************************************
    // Bus answer and interrupt
    // ****************************************
    // No wait state: ready rises in the first access cycle after setup
    always_ff @(posedge CLK_I) begin
        if (RESET_I) begin
            PREADY_O  <= 1'b0;
            PRDATA_O  <= 32'h00000000;
            PSLVERR_O <= 1'b0;
            IRQ_O     <= 1'b0;
        end else begin
            PREADY_O  <= setup_ph;
            PRDATA_O  <= setup_ph ? rd_mux : 32'h00000000;
            PSLVERR_O <= setup_ph && !mapped;
            IRQ_O     <= next_flag & zero_mask;
        end
    end

endmodule

// ### verif/itp_timer_props.sv
// Purpose: Port-level assertions for the prescaled interval timer
// Assumes: One clock, synchronous active-high reset
// Notes:   Bound to every instance of the timer
`timescale 1ns/100ps
module itp_timer_props (
    input wire logic        CLK_I,
    input wire logic        RESET_I,
    input wire logic        PSEL_I,
    input wire logic        PENABLE_I,
    input wire logic        PWRITE_I,
    input wire logic [11:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    input wire logic [31:0] PRDATA_O,
    input wire logic        PREADY_O,
    input wire logic        PSLVERR_O,
    input wire logic        IRQ_O
);
    default clocking @(posedge CLK_I); endclocking
    default disable iff (RESET_I);
    sequence s_rd(a); PSEL_I && PENABLE_I && PREADY_O && !PWRITE_I && PADDR_I == a; endsequence
    chk_count_width: assert property (s_rd(12'h000) |-> PRDATA_O[31:16] == 16'h0) else $error("count too wide");
    chk_scale_width: assert property (s_rd(12'h004) |-> PRDATA_O[31:8] == 24'h0) else $error("scale too wide");
    chk_period_width: assert property (s_rd(12'h008) |-> PRDATA_O[31:16] == 16'h0) else $error("period wide");
    chk_ready_prompt: assert property (PSEL_I && !PENABLE_I |=> PREADY_O) else $error("bus stalled");
    chk_ready_pulse: assert property (PREADY_O |=> !PREADY_O) else $error("ready too long");
    chk_irq_hold: assert property (IRQ_O && !PSEL_I && !$past(PSEL_I) |=> IRQ_O) else $error("irq dropped");
endmodule
bind itp_timer itp_timer_props i_itp_timer_props (.*);

// ### verif/testbench.sv
// Purpose: Self-checking bench for the prescaled interval timer
// Assumes: APB master driven on rising edges, no random stimulus
// Notes:   Prescale 7 gives a tick every 8 cycles to keep the run short
`timescale 1ns/100ps
module testbench;
    logic        clk = 1'b0, rst = 1'b1, sel = 1'b0, en = 1'b0, wr = 1'b0, ready, slverr, irq, serr;
    logic [11:0] addr = 12'h000;
    logic [31:0] wdata = 32'h0, prdata, rdata;
    int          err_count = 0, samples_checked = 0, cyc = 0;
    time         t0;
    logic [11:0] ra [4] = '{12'h004, 12'h008, 12'h010, 12'h01c};
    logic [31:0] rw [4] = '{32'hffff_fff3, 32'hffff_0005, 32'hffff_ffff, 32'h0000_0005};
    logic [31:0] re [4] = '{32'h0000_00f3, 32'h0000_0005, 32'h0000_0001, 32'h0000_0000};
    always #50 clk = ~clk;
    itp_timer i_itp_timer (.CLK_I(clk), .RESET_I(rst), .PSEL_I(sel), .PENABLE_I(en), .PWRITE_I(wr),
        .PADDR_I(addr), .PWDATA_I(wdata), .PRDATA_O(prdata), .PREADY_O(ready), .PSLVERR_O(slverr), .IRQ_O(irq));
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic final_report();
        if (err_count == 0 && samples_checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        {sel, en, wr, addr, wdata} <= {1'b1, 1'b0, w, a, d};
        @(posedge clk);
        en <= 1'b1;
        do @(posedge clk); while (ready !== 1'b1);
        rdata = prdata;
        serr = slverr;
        {sel, en} <= 2'b00;
    endtask
    // Hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            err_count++;
            final_report();
        end
    end
    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        // Count free-runs from reset with prescale 0, so its reset value cannot be read back; prescale reset is checked here
        apb(1'b0, 12'h004, 32'h0);
        check("prescale reset", rdata, 32'h0);
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, ra[i], rw[i]);
            apb(1'b0, ra[i], 32'h0);
            check("readback", rdata, re[i]);
        end
        check("unmapped err", {31'h0, serr}, 32'h1);
        apb(1'b1, 12'h004, 32'h7);
        apb(1'b1, 12'h000, 32'h1);
        while (irq !== 1'b1) @(posedge clk);
        t0 = $time;
        apb(1'b0, 12'h000, 32'h0);
        check("reload", rdata, 32'h5);
        apb(1'b0, 12'h00c, 32'h0);
        check("status", rdata, 32'h1);
        while (irq !== 1'b0) @(posedge clk);
        while (irq !== 1'b1) @(posedge clk);
        check("interval", 32'(($time - t0) / 100), 32'd40);
        apb(1'b1, 12'h010, 32'h0);
        apb(1'b0, 12'h00c, 32'h0);
        repeat (45) @(posedge clk);
        check("masked irq", {31'h0, irq}, 32'h0);
        apb(1'b0, 12'h00c, 32'h0);
        check("masked status", rdata, 32'h1);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        check("reset irq", {31'h0, irq}, 32'h0);
        apb(1'b0, 12'h008, 32'h0);
        check("reset period", rdata, 32'h0);
        apb(1'b0, 12'h00c, 32'h0);
        check("reset status", rdata, 32'h0);
        final_report();
    end
endmodule
